// >>> design/pmceo_consts.svh
`ifndef PMCEO_CONSTS_SVH
`define PMCEO_CONSTS_SVH

// register offsets in the configuration space
`define PMCEO_OFS_MAP_LOW       8'h02
`define PMCEO_OFS_MAP_HIGH      8'h03
`define PMCEO_OFS_CLK_EV_ROUTE  8'h04
`define PMCEO_OFS_EV_CHAN       8'h06

// virtual window space: address[7:4] == base, [3:2] window, [1:0] register
`define PMCEO_WIN_BASE          4'h1
`define PMCEO_VOFS_DIR          2'h0
`define PMCEO_VOFS_OUT          2'h1
`define PMCEO_VOFS_IN           2'h2
`define PMCEO_VOFS_FLAGS        2'h3

// field positions of clock_event_routing
`define PMCEO_ALT_PIN_BIT       7
`define PMCEO_RTC_EN_BIT        6
`define PMCEO_EV_PORT_HI        5
`define PMCEO_EV_PORT_LO        4
`define PMCEO_CLK_SRC_HI        3
`define PMCEO_CLK_SRC_LO        2
`define PMCEO_CLK_PORT_HI       1
`define PMCEO_CLK_PORT_LO       0

// reset values
`define PMCEO_RST_MAP           8'h00
`define PMCEO_RST_ROUTE         8'h00
`define PMCEO_RST_EV_CHAN       3'h0
`define PMCEO_RST_PORT_REG      8'h00
`define PMCEO_RST_FLAGS         2'h0

// sizes
`define PMCEO_NUM_PORTS         16
`define PMCEO_NUM_WIN           4
`define PMCEO_NUM_EVCH          8
`define PMCEO_PINS              8
`define PMCEO_FLAG_BITS         2

// pins and ports used by the routing
`define PMCEO_PORT_C            4'h2
`define PMCEO_RTC_PIN           3'h6
`define PMCEO_DEF_PIN           3'h7
`define PMCEO_ALT_PIN           3'h4

// field codes
`define PMCEO_ROUTE_OFF         2'h0
`define PMCEO_SRC_X1            2'h0
`define PMCEO_SRC_X2            2'h1
`define PMCEO_SRC_X4            2'h2

`endif

// >>> design/pmceo_pkg.sv
package pmceo_pkg;

  typedef logic [3:0] pmceo_port_code_t;
  typedef logic [1:0] pmceo_vreg_t;
  typedef logic [7:0] pmceo_byte_t;

endpackage : pmceo_pkg

// >>> design/pmceo_port_bank.sv
`timescale 1ns/1ps
`include "pmceo_consts.svh"

// direction, output and interrupt-flag registers of all physical ports
module pmceo_port_bank
  import pmceo_pkg::*;
#(
  parameter int NPORTS = `PMCEO_NUM_PORTS
) (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // access from the window decoder
  input  wire logic                   i_wr,
  input  wire pmceo_port_code_t       i_port,
  input  wire pmceo_vreg_t            i_vreg,
  input  wire logic [7:0]             i_wdata,
  // flag events from the pin sense logic
  input  wire logic [NPORTS*2-1:0]    i_flag_set,
  // register contents
  output logic      [NPORTS*8-1:0]    o_dir,
  output logic      [NPORTS*8-1:0]    o_out,
  output logic      [NPORTS*2-1:0]    o_flags
);

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      logic hit;
      assign hit = i_wr && (i_port == pmceo_port_code_t'(p));

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          o_dir[p*8 +: 8] <= `PMCEO_RST_PORT_REG;
        end else if (hit && i_vreg == `PMCEO_VOFS_DIR) begin
          o_dir[p*8 +: 8] <= i_wdata;
        end
      end

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          o_out[p*8 +: 8] <= `PMCEO_RST_PORT_REG;
        end else if (hit && i_vreg == `PMCEO_VOFS_OUT) begin
          o_out[p*8 +: 8] <= i_wdata;
        end
      end

      // write one clears; a new event in the same cycle wins
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          o_flags[p*2 +: 2] <= `PMCEO_RST_FLAGS;
        end else begin
          o_flags[p*2 +: 2] <= ((hit && i_vreg == `PMCEO_VOFS_FLAGS)
                                ? (o_flags[p*2 +: 2] & ~i_wdata[1:0])
                                : o_flags[p*2 +: 2])
                               | i_flag_set[p*2 +: 2];
        end
      end
    end
  endgenerate

endmodule : pmceo_port_bank

// >>> design/pmceo_top.sv
`timescale 1ns/1ps
`include "pmceo_consts.svh"

module pmceo_top
  import pmceo_pkg::*;
(
  // clock and reset
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rst_n,
  // register port
  input  wire logic [7:0]                        i_addr,
  input  wire logic [7:0]                        i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [7:0]                        o_rdata,
  // routed sources
  input  wire logic                              i_peripheral_clock,
  input  wire logic                              i_peripheral_clock_double,
  input  wire logic                              i_peripheral_clock_quad,
  input  wire logic                              i_rtc_clock,
  input  wire logic [`PMCEO_NUM_EVCH-1:0]        i_event_chan,
  // physical ports
  input  wire logic [`PMCEO_NUM_PORTS*8-1:0]     i_pin_in,
  input  wire logic [`PMCEO_NUM_PORTS*2-1:0]     i_flag_set,
  output logic      [`PMCEO_NUM_PORTS*8-1:0]     o_pin_out,
  output logic      [`PMCEO_NUM_PORTS*8-1:0]     o_pin_oe
);

  localparam int NPORTS = `PMCEO_NUM_PORTS;

  // control registers
  pmceo_byte_t virtual_map_low;
  pmceo_byte_t virtual_map_high;
  pmceo_byte_t clock_event_routing;
  logic [2:0]  event_channel_pick;

  // port register bank contents
  logic [NPORTS*8-1:0] bank_dir;
  logic [NPORTS*8-1:0] bank_out;
  logic [NPORTS*2-1:0] bank_flags;

  // window decode
  logic             win_hit;
  logic [1:0]       win_idx;
  pmceo_vreg_t      win_reg;
  pmceo_port_code_t win_port;
  logic             bank_wr;

  // routing fields
  logic             alt_pin_select;
  logic             rtc_clock_pin_enable;
  logic [1:0]       event_port_select;
  logic [1:0]       clock_source_select;
  logic [1:0]       clock_port_select;
  logic [4:0]       clk_port_idx;
  logic [4:0]       ev_port_idx;
  logic [2:0]       route_pin;
  logic             clk_sig;
  logic             ev_sig;

  logic [7:0]          next_rdata;
  logic [NPORTS*8-1:0] next_pin_out;

  // window code lookup, shared by read and write paths
  function automatic pmceo_port_code_t window_port_code(
    input logic [1:0] win,
    input pmceo_byte_t low,
    input pmceo_byte_t high
  );
    pmceo_port_code_t code;
    code = '0;
    case (win)
      2'h0: code = low[3:0];
      2'h1: code = low[7:4];
      2'h2: code = high[3:0];
      default: code = high[7:4];
    endcase
    return code;
  endfunction : window_port_code

  // 01/10/11 to ports C/D/E; off gives an index no port matches
  function automatic logic [4:0] route_port_index(input logic [1:0] sel);
    logic [4:0] idx;
    idx = 5'h1f;
    if (sel != `PMCEO_ROUTE_OFF) begin
      idx = 5'({3'h0, sel} + 5'({1'b0, `PMCEO_PORT_C}) - 5'h1);
    end
    return idx;
  endfunction : route_port_index

  assign win_hit  = (i_addr[7:4] == `PMCEO_WIN_BASE);
  assign win_idx  = i_addr[3:2];
  assign win_reg  = i_addr[1:0];
  assign win_port = window_port_code(win_idx, virtual_map_low, virtual_map_high);
  // input register is driven by the pins; a write there has no effect
  assign bank_wr  = i_wr && win_hit && (win_reg != `PMCEO_VOFS_IN);

  assign alt_pin_select       = clock_event_routing[`PMCEO_ALT_PIN_BIT];
  assign rtc_clock_pin_enable = clock_event_routing[`PMCEO_RTC_EN_BIT];
  assign event_port_select    = clock_event_routing[`PMCEO_EV_PORT_HI:`PMCEO_EV_PORT_LO];
  assign clock_source_select  = clock_event_routing[`PMCEO_CLK_SRC_HI:`PMCEO_CLK_SRC_LO];
  assign clock_port_select    = clock_event_routing[`PMCEO_CLK_PORT_HI:`PMCEO_CLK_PORT_LO];
  assign route_pin = alt_pin_select ? `PMCEO_ALT_PIN : `PMCEO_DEF_PIN;

  // configuration registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      virtual_map_low <= `PMCEO_RST_MAP;
    end else if (i_wr && i_addr == `PMCEO_OFS_MAP_LOW) begin
      virtual_map_low <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      virtual_map_high <= `PMCEO_RST_MAP;
    end else if (i_wr && i_addr == `PMCEO_OFS_MAP_HIGH) begin
      virtual_map_high <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      clock_event_routing <= `PMCEO_RST_ROUTE;
    end else if (i_wr && i_addr == `PMCEO_OFS_CLK_EV_ROUTE) begin
      clock_event_routing <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      event_channel_pick <= `PMCEO_RST_EV_CHAN;
    end else if (i_wr && i_addr == `PMCEO_OFS_EV_CHAN) begin
      event_channel_pick <= i_wdata[2:0];
    end
  end

  pmceo_port_bank #(
    .NPORTS (NPORTS)
  ) u_bank (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_wr       (bank_wr),
    .i_port     (win_port),
    .i_vreg     (win_reg),
    .i_wdata    (i_wdata),
    .i_flag_set (i_flag_set),
    .o_dir      (bank_dir),
    .o_out      (bank_out),
    .o_flags    (bank_flags)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      if (win_hit) begin
        unique case (win_reg)
          `PMCEO_VOFS_DIR:   next_rdata = bank_dir[win_port*8 +: 8];
          `PMCEO_VOFS_OUT:   next_rdata = bank_out[win_port*8 +: 8];
          `PMCEO_VOFS_IN:    next_rdata = i_pin_in[win_port*8 +: 8];
          `PMCEO_VOFS_FLAGS: next_rdata = {6'h00, bank_flags[win_port*2 +: 2]};
        endcase
      end else begin
        case (i_addr)
          `PMCEO_OFS_MAP_LOW:      next_rdata = virtual_map_low;
          `PMCEO_OFS_MAP_HIGH:     next_rdata = virtual_map_high;
          `PMCEO_OFS_CLK_EV_ROUTE: next_rdata = clock_event_routing;
          `PMCEO_OFS_EV_CHAN:      next_rdata = {5'h00, event_channel_pick};
          default:                 next_rdata = 8'h00;
        endcase
      end
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // source selection; reserved source code gives a quiet low level
  always_comb begin
    clk_sig = 1'b0;
    case (clock_source_select)
      `PMCEO_SRC_X1: clk_sig = i_peripheral_clock;
      `PMCEO_SRC_X2: clk_sig = i_peripheral_clock_double;
      `PMCEO_SRC_X4: clk_sig = i_peripheral_clock_quad;
      default:       clk_sig = 1'b0;
    endcase
  end

  assign ev_sig = i_event_chan[event_channel_pick];

  // port fields decoded once, shared by every pin below
  assign clk_port_idx = route_port_index(clock_port_select);
  assign ev_port_idx  = route_port_index(event_port_select);

  // pin multiplexer: clock, then rtc, then event, then ordinary data
  for (genvar gp = 0; gp < NPORTS; gp++) begin : g_mux_port
    for (genvar gb = 0; gb < `PMCEO_PINS; gb++) begin : g_mux_pin
      logic clk_hit;
      logic ev_hit;
      logic rtc_hit;

      assign clk_hit = (clk_port_idx == 5'(gp)) && (route_pin == 3'(gb));
      assign ev_hit  = (ev_port_idx == 5'(gp)) && (route_pin == 3'(gb));
      assign rtc_hit = rtc_clock_pin_enable && (4'(gp) == `PMCEO_PORT_C)
                       && (3'(gb) == `PMCEO_RTC_PIN);

      // clock tested first, so a clash of the two port fields shows the clock
      assign next_pin_out[gp*8+gb] = clk_hit ? clk_sig
                                   : rtc_hit ? i_rtc_clock
                                   : ev_hit  ? ev_sig
                                   : bank_out[gp*8+gb];
    end
  end

  // a clock faster than i_ref_clk is sampled here, so it comes out aliased
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pin_out <= '0;
    end else begin
      o_pin_out <= next_pin_out;
    end
  end

  // routed signals only reach pins whose direction is output
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pin_oe <= '0;
    end else begin
      o_pin_oe <= bank_dir;
    end
  end

endmodule : pmceo_top

// >>> dv/pmceo_top_monitor.sv
`timescale 1ns/1ps
module pmceo_top_monitor (
  // clock and reset
  input wire logic         i_ref_clk,
  input wire logic         i_rst_n,
  // register port
  input wire logic [7:0]   i_addr,
  input wire logic [7:0]   i_wdata,
  input wire logic         i_wr,
  input wire logic         i_rd,
  input wire logic [7:0]   o_rdata,
  // sources and pins
  input wire logic         i_peripheral_clock,
  input wire logic         i_peripheral_clock_double,
  input wire logic         i_peripheral_clock_quad,
  input wire logic         i_rtc_clock,
  input wire logic [7:0]   i_event_chan,
  input wire logic [127:0] o_pin_out,
  input wire logic [127:0] o_pin_oe
);
  // shadow of the config space, rebuilt from bus writes
  logic [7:0] sh [8];
  logic [3:0] srcv;
  logic [6:0] ci, ei;
  logic       cs, es, nw;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      sh <= '{default: 8'h00};
    else if (i_wr && i_addr < 8'h08)
      sh[i_addr[2:0]] <= i_wdata;
  end
  assign srcv = {1'b0, i_peripheral_clock_quad, i_peripheral_clock_double, i_peripheral_clock};
  assign cs = srcv[sh[4][3:2]];
  assign es = i_event_chan[sh[6][2:0]];
  assign ci = {4'(sh[4][1:0]) + 4'h1, sh[4][7] ? 3'h4 : 3'h7};
  assign ei = {4'(sh[4][5:4]) + 4'h1, sh[4][7] ? 3'h4 : 3'h7};
  // no config write this cycle, so the pin reflects the settled fields
  assign nw = !(i_wr && i_addr < 8'h08);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  sequence s_clk_on;
    sh[4][1:0] != 2'h0 && nw;
  endsequence
  sequence s_ev_on;
    sh[4][5:4] != 2'h0 && sh[4][5:4] != sh[4][1:0] && nw;
  endsequence
  AST_RB_LOW: assert property (s_rd(8'h02) |=> o_rdata == sh[2])
    else $error("map low readback wrong");
  AST_RB_HIGH: assert property (s_rd(8'h03) |=> o_rdata == sh[3])
    else $error("map high readback wrong");
  AST_RB_ROUTE: assert property (s_rd(8'h04) |=> o_rdata == sh[4])
    else $error("routing readback wrong");
  AST_RB_EVCH: assert property (s_rd(8'h06) |=> o_rdata == {5'h00, sh[6][2:0]})
    else $error("event channel readback wrong");
  AST_CLK_PIN: assert property (s_clk_on |=> !o_pin_oe[ci] || o_pin_out[ci] == $past(cs))
    else $error("clock pin wrong");
  AST_EV_PIN: assert property (s_ev_on |=> !o_pin_oe[ei] || o_pin_out[ei] == $past(es))
    else $error("event pin wrong");
  AST_RTC_PIN: assert property (sh[4][6] && nw |=> !o_pin_oe[22] || o_pin_out[22] == $past(i_rtc_clock))
    else $error("rtc pin wrong");
  AST_RST: assert property ($rose(i_rst_n) |-> o_pin_oe == '0 && o_pin_out == '0)
    else $error("pins not cleared by reset");
endmodule : pmceo_top_monitor

bind pmceo_top pmceo_top_monitor u_pmceo_top_monitor (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_peripheral_clock(i_peripheral_clock),
  .i_peripheral_clock_double(i_peripheral_clock_double),
  .i_peripheral_clock_quad(i_peripheral_clock_quad), .i_rtc_clock(i_rtc_clock),
  .i_event_chan(i_event_chan), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe)
);

// >>> dv/pmceo_pin_model.sv
`timescale 1ns/1ps
module pmceo_pin_model (
  // clock and reset
  input  wire logic    i_ref_clk,
  input  wire logic    i_rst_n,
  // routed sources
  output logic         o_clk_x1,
  output logic         o_clk_x2,
  output logic         o_clk_x4,
  output logic         o_rtc,
  output logic [7:0]   o_event,
  // pin levels, port p reads {p, ~p}
  output logic [127:0] o_pins
);
  logic [7:0] cnt;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
  end
  // distinct rates so a wrong source pick shows on the pin
  assign o_clk_x1 = cnt[2];
  assign o_clk_x2 = cnt[1];
  assign o_clk_x4 = cnt[0];
  assign o_rtc = cnt[3];
  assign o_event = {4{cnt[1:0]}} ^ 8'h96;
  for (genvar p = 0; p < 16; p++) begin : g_pin
    assign o_pins[p*8 +: 8] = {4'(p), ~4'(p)};
  end
endmodule : pmceo_pin_model

// >>> dv/pmceo_bench.sv
`timescale 1ns/1ps
module pmceo_bench
  import pmceo_pkg::*;
;
  logic         clk, rst_n, wr, rd, c1, c2, c4, rtc;
  logic [7:0]   addr, wdata, rdata, ev;
  logic [31:0]  fset;
  logic [127:0] pin_in, pout, poe;
  wire  [15:0]  srcs = {ev, 3'h0, rtc, 1'b0, c4, c2, c1};
  int           mismatches, n_tests;

  pmceo_top u_pmceo_top (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_peripheral_clock(c1), .i_peripheral_clock_double(c2),
    .i_peripheral_clock_quad(c4), .i_rtc_clock(rtc), .i_event_chan(ev), .i_pin_in(pin_in),
    .i_flag_set(fset), .o_pin_out(pout), .o_pin_oe(poe)
  );
  pmceo_pin_model u_pmceo_pin_model (
    .i_ref_clk(clk), .i_rst_n(rst_n), .o_clk_x1(c1), .o_clk_x2(c2), .o_clk_x4(c4),
    .o_rtc(rtc), .o_event(ev), .o_pins(pin_in)
  );

  task automatic check(string what, pmceo_byte_t seen, pmceo_byte_t exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask : rd_chk

  // source level held before an edge must show on the pin just after it
  task automatic pin_chk(int idx, int sel);
    logic s;
    @(posedge clk);
    repeat (4) begin
      #1 s = srcs[sel];
      @(posedge clk);
      #1 check("pin", {7'h00, pout[idx]}, {7'h00, s});
    end
  endtask : pin_chk

  task automatic t_reset();
    logic [7:0] ra [6] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h05, 8'h10};
    foreach (ra[i]) rd_chk(ra[i], 8'h00);
    rd_chk(8'h12, 8'h0f);
  endtask : t_reset

  task automatic t_map();
    int p;
    wr_reg(8'h02, 8'h73);
    wr_reg(8'h03, 8'hfb);
    rd_chk(8'h03, 8'hfb);
    for (int w = 0; w < 4; w++) begin
      p = w * 4 + 3;
      wr_reg(8'(8'h10 + 4 * w), 8'(8'h30 + w));
      wr_reg(8'(8'h11 + 4 * w), 8'(8'hc0 + w));
      rd_chk(8'(8'h11 + 4 * w), 8'(8'hc0 + w));
      rd_chk(8'(8'h12 + 4 * w), {4'(p), ~4'(p)});
      check("dir", poe[p*8 +: 8], 8'(8'h30 + w));
      check("out", pout[p*8 +: 8], 8'(8'hc0 + w));
    end
  endtask : t_map

  task automatic t_flags();
    wr_reg(8'h02, 8'h05);
    @(posedge clk);
    fset <= 32'h0000_0800;
    @(posedge clk);
    fset <= 32'h0;
    rd_chk(8'h13, 8'h02);
    wr_reg(8'h13, 8'h02);
    rd_chk(8'h13, 8'h00);
  endtask : t_flags

  task automatic t_route();
    logic [7:0] rt [10] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h82, 8'h43, 8'h10, 8'ha0, 8'h30, 8'h22};
    int ix [10] = '{23, 23, 23, 23, 28, 22, 23, 28, 39, 31};
    int sl [10] = '{0, 1, 2, 3, 0, 4, 13, 13, 13, 0};
    wr_reg(8'h02, 8'h32);
    wr_reg(8'h03, 8'h04);
    wr_reg(8'h10, 8'hd0);
    wr_reg(8'h14, 8'hd0);
    wr_reg(8'h18, 8'hd0);
    wr_reg(8'h11, 8'hff);
    wr_reg(8'h06, 8'h05);
    rd_chk(8'h06, 8'h05);
    foreach (rt[i]) begin
      wr_reg(8'h04, rt[i]);
      pin_chk(ix[i], sl[i]);
    end
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h04, 8'h10);
    @(posedge clk);
    #1 check("oe", {7'h00, poe[23]}, 8'h00);
  endtask : t_route

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    fset = 32'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_map();
    t_flags();
    t_route();
    end_of_test();
  end
endmodule : pmceo_bench
